// File: core/dspcg_pkg.sv
// constants and types for the deep-sleep port clock gate
package dspcg_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int PORT_COUNT = 8;
	localparam int SEL_W = 3;
	localparam int STATUS_W = 2;

	localparam logic [ADDR_W-1:0] OFF_SW_RESET_0 = 12'h040;
	localparam logic [ADDR_W-1:0] OFF_DEEP_SLEEP_GATE = 12'h128;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h200;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h204;

	localparam logic [PORT_COUNT-1:0] GATE_RESET = 8'h00;
	localparam logic [DATA_W-1:0] SW_RESET_RESET = 32'h0000_0000;
	localparam logic [STATUS_W-1:0] STATUS_RESET = 2'h0;
	localparam logic [STATUS_W-1:0] MASK_RESET = 2'h0;

	localparam int EVT_PORT_FAULT = 0;
	localparam int EVT_SLEEP_ENTRY = 1;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {
		DSPCG_W_IDLE = 1'b0,
		DSPCG_W_RESP = 1'b1
	} dspcg_wstate_t;

	typedef enum logic [0:0] {
		DSPCG_R_IDLE = 1'b0,
		DSPCG_R_DATA = 1'b1
	} dspcg_rstate_t;
endpackage

// File: core/dspcg_access_check.sv
// fault check for accesses to gated ports
`timescale 1ns/1ps
`default_nettype none
module dspcg_access_check (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// current per-port clock enables
	input wire logic [dspcg_pkg::PORT_COUNT-1:0] port_enable,
	// port access request
	input wire logic access_valid,
	input wire logic [dspcg_pkg::SEL_W-1:0] access_sel,
	// answers, one-cycle pulses
	output logic access_fault,
	output logic access_done
);
	logic fault_d;
	logic done_d;
	logic fault_q;
	logic done_q;

	always_comb begin
		fault_d = access_valid && !port_enable[access_sel]; // RQ4
		done_d = access_valid && port_enable[access_sel];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_q <= 1'b0;
			done_q <= 1'b0;
		end else if (clk_en) begin
			fault_q <= fault_d;
			done_q <= done_d;
		end
	end

	assign access_fault = fault_q;
	assign access_done = done_q;
endmodule
`default_nettype wire

// File: core/dspcg_top.sv
// deep-sleep port clock gate with axi4-lite register slave
// Contract
// RQ1 - Eight writable gating bits, bit 0 for port A up to bit 7 for port H, all zero after reset.
// RQ2 - A port whose gating bit is one gets its clock enable driven high.
// RQ3 - A port whose gating bit is zero has its clock enable held low.
// RQ4 - An access to a port whose clock is off is answered with a fault instead of completion.
// RQ5 - Software keeps bits 31 to 8 of the gating register by read-modify-write and does not rely on them.
// RQ6 - Writes to software reset control 0 at offset 0x040 are masked by device capabilities 1.
// RQ7 - The gating register governs the ports only while the system is in deep sleep.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dspcg_top (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [dspcg_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [dspcg_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [dspcg_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [dspcg_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	// system state and other gating sources
	input wire logic deep_sleep_active,
	input wire logic [dspcg_pkg::PORT_COUNT-1:0] run_port_clock_enable,
	input wire logic [dspcg_pkg::DATA_W-1:0] device_capabilities_1,
	// port access requests
	input wire logic port_access_valid,
	input wire logic [dspcg_pkg::SEL_W-1:0] port_access_sel,
	output logic port_access_fault,
	output logic port_access_done,
	// per-port clock enables
	output logic port_a_clock_enable,
	output logic port_b_clock_enable,
	output logic port_c_clock_enable,
	output logic port_d_clock_enable,
	output logic port_e_clock_enable,
	output logic port_f_clock_enable,
	output logic port_g_clock_enable,
	output logic port_h_clock_enable,
	// software reset outputs and interrupt
	output logic [dspcg_pkg::DATA_W-1:0] software_reset_control_0,
	output logic irq
);
	function automatic logic hit(input logic [dspcg_pkg::ADDR_W-1:0] addr, input logic [dspcg_pkg::ADDR_W-1:0] off);
		hit = (addr[dspcg_pkg::ADDR_W-1:2] == off[dspcg_pkg::ADDR_W-1:2]);
	endfunction

	function automatic logic [dspcg_pkg::DATA_W-1:0] merge(input logic [dspcg_pkg::DATA_W-1:0] old,
			input logic [dspcg_pkg::DATA_W-1:0] val, input logic [3:0] strb);
		logic [dspcg_pkg::DATA_W-1:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = val[i*8 +: 8];
			end
		end
		merge = res;
	endfunction

	// write channel state
	dspcg_pkg::dspcg_wstate_t wstate_q, wstate_d;
	logic aw_held_q, aw_held_d;
	logic w_held_q, w_held_d;
	logic [dspcg_pkg::ADDR_W-1:0] waddr_q, waddr_d;
	logic [dspcg_pkg::DATA_W-1:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_q, awready_d;
	logic wready_q, wready_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	// read channel state
	dspcg_pkg::dspcg_rstate_t rstate_q, rstate_d;
	logic arready_q, arready_d;
	logic rvalid_q, rvalid_d;
	logic [dspcg_pkg::DATA_W-1:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	// registers
	logic [dspcg_pkg::PORT_COUNT-1:0] gate_q, gate_d;
	logic [dspcg_pkg::DATA_W-1:0] swrst_q, swrst_d;
	logic [dspcg_pkg::STATUS_W-1:0] status_q, status_d;
	logic [dspcg_pkg::STATUS_W-1:0] mask_q, mask_d;
	logic [dspcg_pkg::PORT_COUNT-1:0] port_en_q, port_en_d;
	logic sleep_q, sleep_d;
	logic irq_q, irq_d;
	logic fault_pulse;
	logic do_write;
	logic [dspcg_pkg::DATA_W-1:0] wval;
	logic [dspcg_pkg::STATUS_W-1:0] clr;
	logic [dspcg_pkg::STATUS_W-1:0] set;

	dspcg_access_check u_check (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_en(clk_en),
		.port_enable(port_en_q),
		.access_valid(port_access_valid),
		.access_sel(port_access_sel),
		.access_fault(fault_pulse),
		.access_done(port_access_done)
	);

	// write path and register updates
	always_comb begin
		wstate_d = wstate_q;
		aw_held_d = aw_held_q;
		w_held_d = w_held_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		gate_d = gate_q;
		swrst_d = swrst_q;
		mask_d = mask_q;
		clr = '0;
		wval = '0;
		if (awvalid && awready_q) begin
			aw_held_d = 1'b1;
			waddr_d = awaddr;
		end
		if (wvalid && wready_q) begin
			w_held_d = 1'b1;
			wdata_d = wdata;
			wstrb_d = wstrb;
		end
		do_write = (wstate_q == dspcg_pkg::DSPCG_W_IDLE) && aw_held_q && w_held_q;
		unique case (wstate_q)
			dspcg_pkg::DSPCG_W_IDLE: begin
				if (do_write) begin
					aw_held_d = 1'b0;
					w_held_d = 1'b0;
					bvalid_d = 1'b1;
					bresp_d = dspcg_pkg::RESP_OKAY;
					wstate_d = dspcg_pkg::DSPCG_W_RESP;
					if (hit(waddr_q, dspcg_pkg::OFF_DEEP_SLEEP_GATE)) begin
						wval = merge({24'h00_0000, gate_q}, wdata_q, wstrb_q);
						gate_d = wval[dspcg_pkg::PORT_COUNT-1:0]; // RQ1
					end else if (hit(waddr_q, dspcg_pkg::OFF_SW_RESET_0)) begin
						wval = merge(swrst_q, wdata_q, wstrb_q);
						swrst_d = wval & device_capabilities_1; // RQ6
					end else if (hit(waddr_q, dspcg_pkg::OFF_IRQ_STATUS)) begin
						if (wstrb_q[0]) begin
							clr = wdata_q[dspcg_pkg::STATUS_W-1:0];
						end
					end else if (hit(waddr_q, dspcg_pkg::OFF_IRQ_MASK)) begin
						if (wstrb_q[0]) begin
							mask_d = wdata_q[dspcg_pkg::STATUS_W-1:0];
						end
					end else begin
						bresp_d = dspcg_pkg::RESP_SLVERR;
					end
				end
			end
			dspcg_pkg::DSPCG_W_RESP: begin
				if (bready) begin
					bvalid_d = 1'b0;
					wstate_d = dspcg_pkg::DSPCG_W_IDLE;
				end
			end
		endcase
		awready_d = !aw_held_d && (wstate_d == dspcg_pkg::DSPCG_W_IDLE);
		wready_d = !w_held_d && (wstate_d == dspcg_pkg::DSPCG_W_IDLE);
	end

	// read path
	always_comb begin
		rstate_d = rstate_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		unique case (rstate_q)
			dspcg_pkg::DSPCG_R_IDLE: begin
				if (arvalid && arready_q) begin
					rvalid_d = 1'b1;
					rresp_d = dspcg_pkg::RESP_OKAY;
					rstate_d = dspcg_pkg::DSPCG_R_DATA;
					rdata_d = '0;
					if (hit(araddr, dspcg_pkg::OFF_DEEP_SLEEP_GATE)) begin
						rdata_d = {24'h00_0000, gate_q};
					end else if (hit(araddr, dspcg_pkg::OFF_SW_RESET_0)) begin
						rdata_d = swrst_q;
					end else if (hit(araddr, dspcg_pkg::OFF_IRQ_STATUS)) begin
						rdata_d = {30'h0000_0000, status_q};
					end else if (hit(araddr, dspcg_pkg::OFF_IRQ_MASK)) begin
						rdata_d = {30'h0000_0000, mask_q};
					end else begin
						rresp_d = dspcg_pkg::RESP_SLVERR;
					end
				end
			end
			dspcg_pkg::DSPCG_R_DATA: begin
				if (rready) begin
					rvalid_d = 1'b0;
					rstate_d = dspcg_pkg::DSPCG_R_IDLE;
				end
			end
		endcase
		arready_d = (rstate_d == dspcg_pkg::DSPCG_R_IDLE);
	end

	// gating, events and interrupt
	always_comb begin
		sleep_d = deep_sleep_active;
		// outside deep sleep the run-mode source owns the enables
		port_en_d = deep_sleep_active ? gate_q : run_port_clock_enable; // RQ7 RQ2 RQ3
		set = '0;
		set[dspcg_pkg::EVT_PORT_FAULT] = fault_pulse;
		set[dspcg_pkg::EVT_SLEEP_ENTRY] = deep_sleep_active && !sleep_q;
		// a new event beats a same-cycle clear
		status_d = (status_q & ~clr) | set;
		irq_d = |(status_d & mask_d);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wstate_q <= dspcg_pkg::DSPCG_W_IDLE;
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			waddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= 4'h0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= dspcg_pkg::RESP_OKAY;
			rstate_q <= dspcg_pkg::DSPCG_R_IDLE;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= dspcg_pkg::RESP_OKAY;
			gate_q <= dspcg_pkg::GATE_RESET; // RQ1
			swrst_q <= dspcg_pkg::SW_RESET_RESET;
			status_q <= dspcg_pkg::STATUS_RESET;
			mask_q <= dspcg_pkg::MASK_RESET;
			port_en_q <= dspcg_pkg::GATE_RESET;
			sleep_q <= 1'b0;
			irq_q <= 1'b0;
		end else if (clk_en) begin
			wstate_q <= wstate_d;
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rstate_q <= rstate_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			gate_q <= gate_d;
			swrst_q <= swrst_d;
			status_q <= status_d;
			mask_q <= mask_d;
			port_en_q <= port_en_d;
			sleep_q <= sleep_d;
			irq_q <= irq_d;
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign port_access_fault = fault_pulse; // RQ4
	assign port_a_clock_enable = port_en_q[0];
	assign port_b_clock_enable = port_en_q[1];
	assign port_c_clock_enable = port_en_q[2];
	assign port_d_clock_enable = port_en_q[3];
	assign port_e_clock_enable = port_en_q[4];
	assign port_f_clock_enable = port_en_q[5];
	assign port_g_clock_enable = port_en_q[6];
	assign port_h_clock_enable = port_en_q[7];
	assign software_reset_control_0 = swrst_q;
	assign irq = irq_q;
endmodule
`default_nettype wire

// File: verif/dspcg_chk.sv
// assertions on the ports of the deep-sleep port clock gate
`timescale 1ns/1ps
`default_nettype none
module dspcg_chk (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// observed ports
	input wire logic bvalid,
	input wire logic deep_sleep_active,
	input wire logic [7:0] run_port_clock_enable,
	input wire logic [31:0] device_capabilities_1,
	input wire logic port_access_valid,
	input wire logic [2:0] port_access_sel,
	input wire logic port_access_fault,
	input wire logic port_access_done,
	input wire logic port_a_clock_enable,
	input wire logic port_b_clock_enable,
	input wire logic port_c_clock_enable,
	input wire logic port_d_clock_enable,
	input wire logic port_e_clock_enable,
	input wire logic port_f_clock_enable,
	input wire logic port_g_clock_enable,
	input wire logic port_h_clock_enable,
	input wire logic [31:0] software_reset_control_0
);
	wire [7:0] en = {port_h_clock_enable, port_g_clock_enable, port_f_clock_enable, port_e_clock_enable,
		port_d_clock_enable, port_c_clock_enable, port_b_clock_enable, port_a_clock_enable};
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_fault; clk_en && port_access_valid && !en[port_access_sel] |=> port_access_fault && !port_access_done; endproperty
	a_fault: assert property (p_fault) else $error("gated access not faulted");
	property p_done; clk_en && port_access_valid && en[port_access_sel] |=> port_access_done && !port_access_fault; endproperty
	a_done: assert property (p_done) else $error("clocked access not completed");
	property p_cause; port_access_fault || port_access_done |-> $past(port_access_valid); endproperty
	a_cause: assert property (p_cause) else $error("answer without request");
	property p_run; clk_en && !deep_sleep_active |=> en == $past(run_port_clock_enable); endproperty
	a_run: assert property (p_run) else $error("enables ignore run gating");
	// a gate write is the only thing that may move enables inside deep sleep
	property p_hold; $past(aresetn) && deep_sleep_active && $past(deep_sleep_active) && !bvalid |=> $stable(en); endproperty
	a_hold: assert property (p_hold) else $error("enables moved without write");
	property p_rst; !$past(aresetn) |-> en == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("enables not cleared by reset");
	property p_mask; $changed(software_reset_control_0) |-> (software_reset_control_0 & ~$past(device_capabilities_1)) == 32'h0; endproperty
	a_mask: assert property (p_mask) else $error("reset control not masked");
	property p_wr; $changed(software_reset_control_0) |-> $rose(bvalid); endproperty
	a_wr: assert property (p_wr) else $error("reset control moved without write");
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the deep-sleep port clock gate
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic aclk = 0, aresetn = 0, clk_en = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic deep_sleep_active = 0, port_access_valid = 0, awready, wready, arready, rvalid, bvalid, irq;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [2:0] awprot = '0, arprot = '0, port_access_sel = '0;
	logic [3:0] wstrb = 4'hf;
	logic [31:0] wdata = '0, device_capabilities_1 = '0, seed = 32'h3b41, v, rd, rdata, software_reset_control_0;
	logic [7:0] run_port_clock_enable = '0;
	logic [1:0] bresp, rresp, r;
	logic port_access_fault, port_access_done, port_a_clock_enable, port_b_clock_enable, port_c_clock_enable;
	logic port_d_clock_enable, port_e_clock_enable, port_f_clock_enable, port_g_clock_enable, port_h_clock_enable;
	logic [11:0] ag = dspcg_pkg::OFF_DEEP_SLEEP_GATE, asw = dspcg_pkg::OFF_SW_RESET_0;
	logic [11:0] ast = dspcg_pkg::OFF_IRQ_STATUS, amk = dspcg_pkg::OFF_IRQ_MASK;
	int failures = 0, num_checks = 0;
	wire [7:0] en = {port_h_clock_enable, port_g_clock_enable, port_f_clock_enable, port_e_clock_enable,
		port_d_clock_enable, port_c_clock_enable, port_b_clock_enable, port_a_clock_enable};
	dspcg_top uut (.*);
	always #4 aclk = ~aclk;
	function logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function logic [7:0] exp_en(input logic d, input logic [7:0] g, input logic [7:0] rn);
		return d ? g : rn;
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// handshakes are judged at the falling edge so the rising edge never races the slave's flops
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic da, dw, db, ha, hw;
		da = 0;
		dw = 0;
		db = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50 && !db; n++) begin
			@(negedge aclk);
			ha = awready && !da;
			hw = wready && !dw;
			db = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (db) bready <= 1'b0;
			da |= ha;
			dw |= hw;
		end
		if (!db) begin
			failures++;
			end_of_test;
		end
	endtask
	task automatic rdt(input logic [11:0] a);
		logic da, db, ha;
		da = 0;
		db = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50 && !db; n++) begin
			@(negedge aclk);
			ha = arready && !da;
			db = rvalid;
			rd = rdata;
			r = rresp;
			@(posedge aclk);
			if (ha) arvalid <= 1'b0;
			if (db) rready <= 1'b0;
			da |= ha;
		end
		if (!db) begin
			failures++;
			end_of_test;
		end
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		end_of_test;
	end
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rdt(ag);
		chk(rd, 32'h0);
		chk(en, 32'h0);
		deep_sleep_active <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			v = (i == 0) ? 32'hff : (i == 1) ? 32'hffff_ff00 : seed;
			// read-modify-write: reserved bits go back as they were read
			wr(ag, {rd[31:8], v[7:0]});
			chk(r, dspcg_pkg::RESP_OKAY);
			rdt(ag);
			chk(rd, {24'h0, v[7:0]});
			@(negedge aclk);
			chk(en, exp_en(1'b1, v[7:0], run_port_clock_enable));
			// back-to-back accesses, one per port
			for (int s = 0; s < 9; s++) begin
				@(posedge aclk);
				port_access_valid <= (s < 8);
				port_access_sel <= s[2:0];
				@(negedge aclk);
				if (s > 0) chk({port_access_fault, port_access_done}, {!v[s-1], v[s-1]});
			end
		end
		for (int i = 0; i < 3; i++) begin
			@(posedge aclk);
			deep_sleep_active <= 1'b0;
			seed = xs(seed);
			run_port_clock_enable <= seed[7:0];
			@(posedge aclk);
			@(negedge aclk);
			chk(en, exp_en(1'b0, v[7:0], seed[7:0]));
		end
		// clock enable low must freeze the enables
		@(posedge aclk);
		clk_en <= 1'b0;
		run_port_clock_enable <= ~seed[7:0];
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk(en, exp_en(1'b0, v[7:0], seed[7:0]));
		@(posedge aclk);
		clk_en <= 1'b1;
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk(en, exp_en(1'b0, v[7:0], ~seed[7:0]));
		for (int i = 0; i < 4; i++) begin
			@(posedge aclk);
			seed = xs(seed);
			device_capabilities_1 <= seed;
			seed = xs(seed);
			wr(asw, seed);
			rdt(asw);
			chk(rd, seed & device_capabilities_1);
			chk(software_reset_control_0, seed & device_capabilities_1);
		end
		// single byte lane: the other lanes keep the stored value
		wstrb <= 4'h2;
		wr(asw, 32'hffff_ffff);
		wstrb <= 4'hf;
		rdt(asw);
		chk(rd, (seed | 32'h0000_ff00) & device_capabilities_1);
		wr(12'h300, 32'hffff_ffff);
		chk(r, dspcg_pkg::RESP_SLVERR);
		rdt(12'h300);
		chk(rd, 32'h0);
		chk(r, dspcg_pkg::RESP_SLVERR);
		chk(irq, 1'b0);
		wr(amk, 32'h3);
		@(negedge aclk);
		chk(irq, 1'b1);
		rdt(ast);
		chk(rd, 32'h3);
		wr(ast, 32'h3);
		@(negedge aclk);
		chk(irq, 1'b0);
		@(posedge aclk);
		deep_sleep_active <= 1'b1;
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk(irq, 1'b1);
		rdt(ast);
		chk(rd, 32'h2);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk({en, irq}, 9'h0);
		chk(software_reset_control_0, 32'h0);
		rdt(ag);
		chk(rd, 32'h0);
		chk(r, dspcg_pkg::RESP_OKAY);
		end_of_test;
	end
endmodule
bind dspcg_top dspcg_chk u_chk (.*);
`default_nettype wire
